// [verilog/ueb_pkg.sv]
`default_nettype none
package ueb_pkg;
    // Directly addressed registers
    localparam logic [11:0] UEB_ADDR_SUBDATA = 12'hF5A;
    localparam logic [11:0] UEB_ADDR_RESUME_CTL = 12'hF5F;

    // Subaddress selector codes
    localparam logic [7:0] UEB_SA_OUT1 = 8'h01;
    localparam logic [7:0] UEB_SA_OUT2 = 8'h02;
    localparam logic [7:0] UEB_SA_OUT3 = 8'h03;
    localparam logic [7:0] UEB_SA_IN_BASE = 8'h08;
    localparam logic [7:0] UEB_SA_IN1 = 8'h09;
    localparam logic [7:0] UEB_SA_IN2 = 8'h0A;
    localparam logic [7:0] UEB_SA_IN3 = 8'h0B;

    // Resume control fields
    localparam int UEB_BIT_REMOTE_RESUME_START = 0;
    localparam int UEB_BIT_RESUME_IRQ_ENABLE = 1;
    localparam logic [7:0] UEB_RESUME_CTL_RST = 8'h00;

    // Values after reset
    localparam logic [7:0] UEB_OUT1_RST = 8'h20;
    localparam logic [7:0] UEB_OUT2_RST = 8'h40;
    localparam logic [7:0] UEB_OUT3_RST = 8'h60;
    localparam logic [6:0] UEB_IN_BASE_RST = 7'h04;
    localparam logic [7:0] UEB_IN1_RST = 8'h20;
    localparam logic [7:0] UEB_IN2_RST = 8'h40;
    localparam logic [7:0] UEB_IN3_RST = 8'h60;

    // Idle time measured before a remote resume, least time
    localparam int UEB_CLK_PERIOD_NS = 10;
    localparam int UEB_IDLE_TIME_NS = 10000;
    localparam int UEB_IDLE_CYCLES =
        (UEB_IDLE_TIME_NS + UEB_CLK_PERIOD_NS - 1) / UEB_CLK_PERIOD_NS;
    localparam logic [9:0] UEB_IDLE_LAST = 10'(UEB_IDLE_CYCLES - 1);

    typedef enum logic [1:0] {
        UEB_ST_IDLE = 2'b01,
        UEB_ST_TIMING = 2'b10
    } ueb_state_e;
endpackage
`default_nettype wire

// [verilog/ueb_buffer_map_resume.sv]
`timescale 1ns/1ns
`default_nettype none
// Function
// R1: With enable clear, only host resume interrupts; needs no PLL clock.
// R2: With enable set, remote resume interrupts after idle timing completes.
// R3: Writing wake-up 1 starts remote resume; 0 starts nothing.
// R4: Hardware clears wake-up once waking with the USB clock running.
// R5: Software should set the interrupt enable along with wake-up.
// R6: Control bits 7:2 read zero; software writes them zero.
// R7: OUT endpoint 0 buffer always starts at address zero.
// R8: OUT address is zero, start value, zero: two-byte steps.
// R9: OUT size is twice the difference of consecutive start values.
// R10: Software sets unused OUT start values to zero.
// R11: OUT 1..3 start values reset to 20h, 40h, 60h.
// R12: Start address subregisters take writes and read back zero.
// R13: OUT 1..3 start values sit at subaddress 01h, 02h, 03h.
// R14: IN region base at subaddress 08h; top bit written zero.
// R15: IN 1..3 start values sit at subaddress 09h, 0Ah, 0Bh.
// R16: IN region base shifted left two gives IN endpoint 0 address.
// R17: Top OUT size is twice (twice base minus its start value).
// R18: IN address is base address plus start value shifted left one.
// R19: IN size is twice the difference of consecutive start values.
// R20: Software sets unused IN start values to zero.
// R21: IN 1..3 start values reset to 20h, 40h, 60h.
// R22: Subdata portal reaches the subregister the selector names.
// R23: Start values are held and drive buffer addresses.
module ueb_buffer_map_resume
    import ueb_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire logic [11:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    input wire logic [7:0] subaddress_selector,
    output logic subdata_hit,
    // Resume
    input wire logic host_resume_pin,
    input wire logic usb_clk_running,
    output logic resume_irq,
    output logic remote_resume_active,
    // Buffer map
    output logic [3:0][9:0] out_buf_addr,
    output logic [3:0][9:0] out_buf_size,
    output logic [3:0][9:0] in_buf_addr,
    output logic [2:0][9:0] in_buf_size
);

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    logic host_resume_q;
    logic host_rise;
    logic usb_clk_ok;
    logic resume_irq_enable;
    logic remote_resume_start;
    ueb_state_e state;
    logic [9:0] idle_cnt;
    logic timing_done;
    logic ctl_wr;
    logic sub_wr;
    logic [7:0] out_start [1:3];
    logic [7:0] in_start [1:3];
    logic [6:0] in_base;

    assign ctl_wr = cpu_wr && cpu_addr == UEB_ADDR_RESUME_CTL;
    assign sub_wr = cpu_wr && cpu_addr == UEB_ADDR_SUBDATA;

    ////////////////////////////////////////////////////////////////////////
    // Pin inputs, two flops each
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_a <= 2'h0;
            sync_b <= 2'h0;
            host_resume_q <= 1'b0;
        end
        else
        begin
            sync_a <= {usb_clk_running, host_resume_pin};
            sync_b <= sync_a;
            host_resume_q <= sync_b[0];
        end
    end

    assign usb_clk_ok = sync_b[1];
    // Host resume needs no PLL clock: only the system clock samples it
    assign host_rise = sync_b[0] && !host_resume_q; // see R1

    ////////////////////////////////////////////////////////////////////////
    // Resume control register
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            resume_irq_enable <= UEB_RESUME_CTL_RST[UEB_BIT_RESUME_IRQ_ENABLE];
        else if (ctl_wr)
            resume_irq_enable <= cpu_wdata[UEB_BIT_RESUME_IRQ_ENABLE];
    end

    // Software write wins over the hardware clear so a new start is kept
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            remote_resume_start <= UEB_RESUME_CTL_RST[UEB_BIT_REMOTE_RESUME_START];
        else if (ctl_wr)
            remote_resume_start <= cpu_wdata[UEB_BIT_REMOTE_RESUME_START]; // see R3
        else if (state == UEB_ST_IDLE && usb_clk_ok)
            remote_resume_start <= 1'b0; // see R4
    end

    ////////////////////////////////////////////////////////////////////////
    // Idle timing for a remote resume
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= UEB_ST_IDLE;
            idle_cnt <= 10'h000;
        end
        else
        begin
            case (state)
                UEB_ST_IDLE:
                begin
                    idle_cnt <= 10'h000;
                    if (remote_resume_start && usb_clk_ok)
                        state <= UEB_ST_TIMING; // see R3
                end
                UEB_ST_TIMING:
                begin
                    idle_cnt <= idle_cnt + 10'h001;
                    if (idle_cnt == UEB_IDLE_LAST)
                        state <= UEB_ST_IDLE;
                end
                default:
                    state <= UEB_ST_IDLE;
            endcase
        end
    end

    assign timing_done = state == UEB_ST_TIMING && idle_cnt == UEB_IDLE_LAST;
    assign remote_resume_active = state == UEB_ST_TIMING;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            resume_irq <= 1'b0;
        else
            resume_irq <= host_rise
                || (timing_done && resume_irq_enable); // see R1 see R2
    end

    ////////////////////////////////////////////////////////////////////////
    // Start address subregisters, written through the portal
    genvar i;
    generate
        for (i = 1; i <= 3; i++)
        begin : g_start
            localparam logic [7:0] SA_OUT = UEB_SA_OUT1 + 8'(i - 1);
            localparam logic [7:0] SA_IN = UEB_SA_IN1 + 8'(i - 1);
            localparam logic [7:0] OUT_RST = (i == 1) ? UEB_OUT1_RST
                : (i == 2) ? UEB_OUT2_RST : UEB_OUT3_RST;
            localparam logic [7:0] IN_RST = (i == 1) ? UEB_IN1_RST
                : (i == 2) ? UEB_IN2_RST : UEB_IN3_RST;
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    out_start[i] <= OUT_RST; // see R11
                    in_start[i] <= IN_RST; // see R21
                end
                else if (sub_wr)
                begin
                    if (subaddress_selector == SA_OUT)
                        out_start[i] <= cpu_wdata; // see R13 see R23
                    if (subaddress_selector == SA_IN)
                        in_start[i] <= cpu_wdata; // see R15 see R23
                end
            end
            assign out_buf_addr[i] = {1'b0, out_start[i], 1'b0}; // see R8
            assign in_buf_addr[i] = {1'b0, in_base, 2'b00}
                + {1'b0, in_start[i], 1'b0}; // see R18
            assign in_buf_size[i - 1] =
                in_buf_addr[i] - in_buf_addr[i - 1]; // see R19
            if (i < 3)
            begin : g_out_size
                assign out_buf_size[i] =
                    out_buf_addr[i + 1] - out_buf_addr[i]; // see R9
            end
        end
    endgenerate

    // Bit 7 of the base is reserved; it is dropped, not stored
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            in_base <= UEB_IN_BASE_RST;
        else if (sub_wr && subaddress_selector == UEB_SA_IN_BASE)
            in_base <= cpu_wdata[6:0]; // see R14
    end

    assign out_buf_addr[0] = 10'h000; // see R7
    assign out_buf_size[0] = out_buf_addr[1] - out_buf_addr[0]; // see R9
    assign out_buf_size[3] = in_buf_addr[0] - out_buf_addr[3]; // see R17
    assign in_buf_addr[0] = {1'b0, in_base, 2'b00}; // see R16

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb
    begin
        case (subaddress_selector)
            UEB_SA_OUT1, UEB_SA_OUT2, UEB_SA_OUT3, UEB_SA_IN_BASE,
            UEB_SA_IN1, UEB_SA_IN2, UEB_SA_IN3:
                subdata_hit = cpu_addr == UEB_ADDR_SUBDATA; // see R22
            default:
                subdata_hit = 1'b0;
        endcase
    end

    // Subregisters here are write-only: a portal read returns zero
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            cpu_rdata <= 8'h00;
        else if (cpu_rd)
        begin
            if (cpu_addr == UEB_ADDR_RESUME_CTL)
                cpu_rdata <= {6'h00, resume_irq_enable,
                    remote_resume_start}; // see R6
            else
                cpu_rdata <= 8'h00; // see R12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Independent count of timing cycles, too long for a plain delay
    logic [10:0] chk_timing_len;

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            chk_timing_len <= 11'h000;
        else if (state == UEB_ST_TIMING)
            chk_timing_len <= chk_timing_len + 11'h001;
        else
            chk_timing_len <= 11'h000;
    end

    property p_host_irq;
        host_rise |=> resume_irq;
    endproperty
    a_host_irq: assert property (p_host_irq) // see R1
        else $error("host resume gave no interrupt");

    property p_remote_irq_gated;
        timing_done && !resume_irq_enable && !host_rise |=> !resume_irq;
    endproperty
    a_remote_irq_gated: assert property (p_remote_irq_gated) // see R2
        else $error("remote resume interrupt while disabled");

    property p_no_start;
        state == UEB_ST_IDLE && !remote_resume_start
            |=> state == UEB_ST_IDLE;
    endproperty
    a_no_start: assert property (p_no_start) // see R3
        else $error("remote resume started without wake-up");

    property p_wake_clear;
        state == UEB_ST_IDLE && remote_resume_start && usb_clk_ok && !ctl_wr
            |=> !remote_resume_start && state == UEB_ST_TIMING;
    endproperty
    a_wake_clear: assert property (p_wake_clear) // see R4
        else $error("wake-up not cleared or timing not started");

    property p_idle_len;
        state == UEB_ST_TIMING ##1 state == UEB_ST_IDLE
            |-> chk_timing_len == 11'(UEB_IDLE_CYCLES);
    endproperty
    a_idle_len: assert property (p_idle_len) // see R2
        else $error("idle timing length wrong");

    property p_ctl_read;
        cpu_rd && cpu_addr == UEB_ADDR_RESUME_CTL
            |=> cpu_rdata[7:2] == 6'h00
            && cpu_rdata[1] == $past(resume_irq_enable)
            && cpu_rdata[0] == $past(remote_resume_start);
    endproperty
    a_ctl_read: assert property (p_ctl_read) // see R6
        else $error("resume control read wrong");

    property p_out0_fixed;
        out_buf_addr[0] == 10'h000
            && out_buf_size[0] == {1'b0, out_start[1], 1'b0};
    endproperty
    a_out0_fixed: assert property (p_out0_fixed) // see R7
        else $error("OUT endpoint 0 map wrong");

    property p_out1_write;
        sub_wr && subaddress_selector == UEB_SA_OUT1
            |=> out_buf_addr[1] == {1'b0, $past(cpu_wdata), 1'b0};
    endproperty
    a_out1_write: assert property (p_out1_write) // see R8
        else $error("OUT endpoint 1 address not updated");

    property p_sub_read_zero;
        cpu_rd && subdata_hit |=> cpu_rdata == 8'h00;
    endproperty
    a_sub_read_zero: assert property (p_sub_read_zero) // see R12
        else $error("start address subregister read not zero");

    property p_base_write;
        sub_wr && subaddress_selector == UEB_SA_IN_BASE
            |=> in_buf_addr[0] == {1'b0, $past(cpu_wdata[6:0]), 2'b00};
    endproperty
    a_base_write: assert property (p_base_write) // see R16
        else $error("IN region base not applied");

endmodule
`default_nettype wire

// [test/ueb_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ueb_host_model #(
    parameter int HOLD = 20
)(
    // Clock and commands from the bench
    input wire logic clk_sys,
    input wire logic resume_req,
    input wire logic clk_on,
    // Bus side levels
    output logic host_resume_pin,
    output logic usb_clk_running
);
    int cnt = 0;
    // Resume signalling lasts a fixed time once started
    always @(posedge clk_sys)
    begin
        if (resume_req && cnt == 0)
            cnt <= HOLD;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // Async levels: move off the clock edge on purpose
    assign #3 host_resume_pin = (cnt > 0);
    assign #3 usb_clk_running = clk_on;
endmodule
`default_nettype wire

// [test/test_ueb_buffer_map_resume.sv]
`timescale 1ns/1ns
`default_nettype none
module test_ueb_buffer_map_resume;
    import ueb_pkg::*;
    logic clk_sys = 0;
    logic arst_n = 0;
    logic [11:0] cpu_addr = 12'h000;
    logic cpu_wr = 0;
    logic cpu_rd = 0;
    logic [7:0] cpu_wdata = 8'h00;
    logic [7:0] sel = 8'h00;
    logic resume_req = 0;
    logic clk_on = 0;
    logic host_pin, usb_run, hit, irq, active;
    logic [7:0] cpu_rdata;
    logic [3:0][9:0] out_addr, out_size, in_addr;
    logic [2:0][9:0] in_size;
    logic [7:0] o1, o2, o3, i1, i2, i3;
    logic [6:0] base;
    logic [7:0] sa [7] = '{8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0A, 8'h0B};
    logic [7:0] vals [7] = '{8'h10, 8'h38, 8'h50, 8'h7F, 8'h08, 8'h30, 8'hFF};
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int n_irq = 0;
    int n;

    always #5 clk_sys = ~clk_sys;

    ueb_buffer_map_resume i_dut (
        .clk_sys(clk_sys), .arst_n(arst_n), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .subaddress_selector(sel),
        .subdata_hit(hit), .host_resume_pin(host_pin),
        .usb_clk_running(usb_run), .resume_irq(irq),
        .remote_resume_active(active), .out_buf_addr(out_addr),
        .out_buf_size(out_size), .in_buf_addr(in_addr),
        .in_buf_size(in_size)
    );

    ueb_host_model #(.HOLD(20)) i_host (
        .clk_sys(clk_sys), .resume_req(resume_req), .clk_on(clk_on),
        .host_resume_pin(host_pin), .usb_clk_running(usb_run)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(string what, logic [9:0] seen, logic [9:0] want);
        n_checks++;
        if (seen !== want)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, want, seen);
        end
    endtask

    // Hang guard; run needs about 2250 cycles
    always @(posedge clk_sys)
    begin
        cycles++;
        if (irq === 1'b1)
            n_irq++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end

    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Strobes stay up so calls run back to back
    task automatic wr(logic [11:0] a, logic [7:0] s, logic [7:0] d);
        cpu_rd = 0;
        cpu_wr = 1;
        cpu_addr = a;
        sel = s;
        cpu_wdata = d;
        tick(1);
    endtask

    task automatic rd(logic [11:0] a, logic [7:0] s, logic [7:0] want);
        cpu_wr = 0;
        cpu_rd = 1;
        cpu_addr = a;
        sel = s;
        tick(1);
        check("rdata", cpu_rdata, want);
    endtask

    task automatic idle();
        cpu_wr = 0;
        cpu_rd = 0;
        tick(1);
    endtask

    task automatic check_map();
        logic [3:0][9:0] ea, ei;
        ea[0] = 10'h000;
        ea[1] = {1'b0, o1, 1'b0};
        ea[2] = {1'b0, o2, 1'b0};
        ea[3] = {1'b0, o3, 1'b0};
        ei[0] = {1'b0, base, 2'b00};
        ei[1] = ei[0] + {1'b0, i1, 1'b0};
        ei[2] = ei[0] + {1'b0, i2, 1'b0};
        ei[3] = ei[0] + {1'b0, i3, 1'b0};
        check("out_addr0", out_addr[0], ea[0]);
        check("out_size3", out_size[3], ei[0] - ea[3]);
        for (int k = 0; k < 4; k++)
        begin
            check("out_addr", out_addr[k], ea[k]);
            check("in_addr", in_addr[k], ei[k]);
        end
        for (int k = 0; k < 3; k++)
        begin
            check("out_size", out_size[k], ea[k+1] - ea[k]);
            check("in_size", in_size[k], ei[k+1] - ei[k]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (16) @(posedge clk_sys);
        #1;
        arst_n = 1;
        {o1, o2, o3, i1, i2, i3} = {8'h20, 8'h40, 8'h60, 8'h20, 8'h40, 8'h60};
        base = 7'h04;
        check_map();
        rd(12'hF5F, 8'h00, 8'h00);
        // Back-to-back writes, then two that must be ignored
        for (int k = 0; k < 7; k++)
            wr(12'hF5A, sa[k], vals[k]);
        wr(12'hF5B, 8'h01, 8'h77);
        wr(12'hF5A, 8'h10, 8'h77);
        idle();
        {o1, o2, o3, i1, i2, i3} = {8'h10, 8'h38, 8'h50, 8'h08, 8'h30, 8'hFF};
        base = 7'h7F;
        check_map();
        for (int k = 0; k < 7; k++)
        begin
            rd(12'hF5A, sa[k], 8'h00);
            check("hit", hit, 1'b1);
        end
        rd(12'hF5A, 8'h10, 8'h00);
        check("hit", hit, 1'b0);
        // Unused endpoints zeroed by software
        wr(12'hF5A, 8'h03, 8'h00);
        wr(12'hF5A, 8'h0B, 8'h00);
        idle();
        o3 = 8'h00;
        i3 = 8'h00;
        check_map();
        // Wake-up waits while the USB clock is stopped
        wr(12'hF5F, 8'h00, 8'h03);
        idle();
        tick(20);
        rd(12'hF5F, 8'h00, 8'h03);
        check("active", active, 1'b0);
        n_irq = 0;
        clk_on = 1;
        idle();
        n = 0;
        while (active !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        n = 0;
        while (active === 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        check("idle_len", n[9:0], 10'(UEB_IDLE_CYCLES));
        tick(5);
        check("irq_count", n_irq[9:0], 10'd1);
        rd(12'hF5F, 8'h00, 8'h02);
        // Enable clear: remote resume gives no interrupt
        wr(12'hF5F, 8'h00, 8'h01);
        idle();
        check("active", active, 1'b1);
        n_irq = 0;
        tick(1100);
        check("irq_count", n_irq[9:0], 10'd0);
        rd(12'hF5F, 8'h00, 8'h00);
        // Host resume with the clock stopped still interrupts
        clk_on = 0;
        resume_req = 1;
        idle();
        resume_req = 0;
        tick(40);
        check("irq_count", n_irq[9:0], 10'd1);
        // Enable only, wake-up clear: no remote resume
        clk_on = 1;
        wr(12'hF5F, 8'h00, 8'h02);
        idle();
        tick(20);
        check("active", active, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
